// ---- pkg/psfc_pkg.sv ----
// constants, register map and carrier types of the power sequencer fault control block
// Summary of operation
// - five-bit under-voltage retry limit per converter
// - master keeps under-voltage slave shutdown style
// - five-bit over-current retry limit per converter
// - master keeps over-current slave shutdown style
// - fault pin enable gates only fault pin
// - fault detect mask, all set at start
// - fault flags per converter; read drops pin
// - warn pin enable gates only warn pin
// - warning enable mask, all clear at start
// - sticky warning flags cleared by read
// - per-converter state code readable, codes 0-7
// - immediate drops enable; soft waits delay
// - fault in on state drops enable at once
package psfc_pkg;
   localparam int NCONV = 32;
   localparam int AW = 8;
   // sequencing tick
   localparam int TICK_US = 250;
   localparam int CLK_MHZ = 100;
   localparam int TICK_CYC = TICK_US * CLK_MHZ;
   localparam logic [3:0] PD_TMO_TICKS = 4'h8;
   localparam logic [4:0] RETRY_UNLIM = 5'h1F;
   // register offsets
   localparam logic [AW-1:0] A_INDEX = 8'h00;
   localparam logic [AW-1:0] A_CFG = 8'h04;
   localparam logic [AW-1:0] A_STATE = 8'h08;
   localparam logic [AW-1:0] A_PIN_EN = 8'h0C;
   localparam logic [AW-1:0] A_FMASK = 8'h10;
   localparam logic [AW-1:0] A_FFLAGS = 8'h14;
   localparam logic [AW-1:0] A_WMASK = 8'h18;
   localparam logic [AW-1:0] A_WFLAGS = 8'h1C;
   localparam logic [AW-1:0] A_SLAVE = 8'h20;
   localparam logic [AW-1:0] A_ON_REQ = 8'h24;
   localparam logic [AW-1:0] A_IRQ_STS = 8'h28;
   localparam logic [AW-1:0] A_IRQ_CLR = 8'h2C;
   localparam logic [AW-1:0] A_IRQ_EN = 8'h30;
   // field positions of the converter configuration and state words
   localparam int F_UV_LIM = 0;
   localparam int F_UV_SOFT = 5;
   localparam int F_OC_LIM = 8;
   localparam int F_OC_SOFT = 13;
   localparam int F_PD_DLY = 16;
   localparam int F_UV_CNT = 8;
   localparam int F_OC_CNT = 16;
   // values after reset
   localparam logic [5:0] RST_INDEX = 6'h01;
   localparam logic [1:0] RST_PIN_EN = 2'h3;
   localparam logic [31:0] RST_FMASK = 32'hFFFF_FFFF;
   localparam logic [31:0] RST_WMASK = 32'h0000_0000;
   // interrupt status bits
   localparam int IRQ_FAULT = 0;
   localparam int IRQ_WARN = 1;
   localparam int IRQ_GIVEUP = 2;
   typedef enum logic [2:0] {
      ST_OFF = 3'h0,
      ST_AWAIT_UP = 3'h1,
      ST_PU_DELAY = 3'h2,
      ST_PU_WAIT = 3'h3,
      ST_ON = 3'h4,
      ST_PD_DELAY = 3'h5,
      ST_PD_WAIT = 3'h6,
      ST_RESEQ = 3'h7
   } psfc_state_t;
   typedef struct packed {
      logic [7:0] pd_delay;
      logic oc_soft;
      logic [4:0] oc_lim;
      logic uv_soft;
      logic [4:0] uv_lim;
   } psfc_cfg_t;
   typedef struct packed {
      logic [AW-1:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } psfc_bus_t;
endpackage : psfc_pkg

// ---- core/psfc_top.sv ----
// fault, warning and state reporting logic of a 32-converter power sequencer
//
// Implementation choices: strobed register access and the register addresses.
`timescale 1ns/100ps
module psfc_top #(
   parameter int TICK_CYCLES = psfc_pkg::TICK_CYC
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst_b,
   // register port
   input wire psfc_pkg::psfc_bus_t i_bus,
   output logic [31:0] o_rdata,
   // converter pins
   input wire logic [psfc_pkg::NCONV-1:0] i_pgood,
   input wire logic [psfc_pkg::NCONV-1:0] i_uv,
   input wire logic [psfc_pkg::NCONV-1:0] i_oc,
   output logic [psfc_pkg::NCONV-1:0] o_en,
   // alarm pins
   output logic o_fault,
   output logic o_warn,
   output logic o_irq
);
   import psfc_pkg::*;

   logic rst_s1_q, rst_n;
   logic [NCONV-1:0] pg_m_q, pg_s_q, uv_m_q, uv_s_q, oc_m_q, oc_s_q;
   logic [14:0] tick_cnt_q;
   logic tick_q;
   logic [5:0] idx_q;
   logic [1:0] pin_en_q;
   logic [31:0] fmask_q, wmask_q, fflags_q, wflags_q, slave_q, onreq_q;
   logic [2:0] irq_sts_q, irq_en_q;
   logic [NCONV-1:0] fault_ev, warn_raw, giveup_ev, imm_req, soft_req, en_w;
   logic [NCONV-1:0] warn_ev;
   logic kill_imm, kill_soft, idx_ok, rd_fflags, rd_wflags;
   logic [4:0] idx_m1;
   psfc_cfg_t cfg_w [NCONV];
   logic [2:0] st_w [NCONV];
   logic [4:0] uvc_w [NCONV];
   logic [4:0] occ_w [NCONV];

   // reset release through two flops
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         rst_s1_q <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_n <= rst_s1_q;
      end
   end

   // converter pins are asynchronous to the block clock
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         pg_m_q <= '0;
         pg_s_q <= '0;
         uv_m_q <= '0;
         uv_s_q <= '0;
         oc_m_q <= '0;
         oc_s_q <= '0;
      end else begin
         pg_m_q <= i_pgood;
         pg_s_q <= pg_m_q;
         uv_m_q <= i_uv;
         uv_s_q <= uv_m_q;
         oc_m_q <= i_oc;
         oc_s_q <= oc_m_q;
      end
   end

   // sequencing tick; slow work runs here, fault shutdown does not wait for it
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         tick_cnt_q <= '0;
         tick_q <= 1'b0;
      end else if (tick_cnt_q == 15'(TICK_CYCLES - 1)) begin
         tick_cnt_q <= '0;
         tick_q <= 1'b1;
      end else begin
         tick_cnt_q <= 15'(tick_cnt_q + 15'h0001);
         tick_q <= 1'b0;
      end
   end

   // out-of-range index makes per-converter accesses inert
   assign idx_ok = (idx_q != 6'h00) && (idx_q <= 6'(NCONV));
   assign idx_m1 = 5'(idx_q - 6'h01);
   assign rd_fflags = i_bus.rd && (i_bus.addr == A_FFLAGS);
   assign rd_wflags = i_bus.rd && (i_bus.addr == A_WFLAGS);
   assign kill_imm = |imm_req;
   assign kill_soft = |soft_req;
   assign warn_ev = warn_raw & wmask_q;

   for (genvar k = 0; k < NCONV; k++) begin : g_conv
      psfc_cfg_t cfg_q;
      psfc_state_t st_q;
      logic en_q, pend_q, pend_uv_q, gave_up_q;
      logic [4:0] uv_cnt_q, oc_cnt_q, lim, cnt;
      logic [7:0] dly_q;
      logic [3:0] tmo_q;
      logic live, uv_hit, oc_hit, f_ev, lim_ok, kill_me;

      always_ff @(posedge i_clk or negedge rst_n) begin
         if (!rst_n) begin
            cfg_q <= '0;
         end else if (i_bus.wr && i_bus.addr == A_CFG && idx_ok && idx_m1 == 5'(k)) begin
            cfg_q.uv_lim <= i_bus.wdata[F_UV_LIM +: 5];
            cfg_q.uv_soft <= i_bus.wdata[F_UV_SOFT];
            cfg_q.oc_lim <= i_bus.wdata[F_OC_LIM +: 5];
            cfg_q.oc_soft <= i_bus.wdata[F_OC_SOFT];
            cfg_q.pd_delay <= i_bus.wdata[F_PD_DLY +: 8];
         end
      end

      // a fault-masked converter never reports a fault; one fault is handled at a time
      assign live = (st_q == ST_ON) && en_q && fmask_q[k] && !pend_q;
      assign uv_hit = live && uv_s_q[k];
      assign oc_hit = live && oc_s_q[k] && !uv_s_q[k];
      assign f_ev = uv_hit || oc_hit;
      assign imm_req[k] = (uv_hit && !cfg_q.uv_soft) || (oc_hit && !cfg_q.oc_soft);
      assign soft_req[k] = (uv_hit && cfg_q.uv_soft) || (oc_hit && cfg_q.oc_soft);
      assign kill_me = slave_q[k] && !f_ev && (kill_imm || kill_soft)
         && (st_q == ST_PU_DELAY || st_q == ST_PU_WAIT || st_q == ST_ON);
      assign lim = pend_uv_q ? cfg_q.uv_lim : cfg_q.oc_lim;
      assign cnt = pend_uv_q ? uv_cnt_q : oc_cnt_q;
      assign lim_ok = (lim == RETRY_UNLIM) || (cnt < lim);
      assign giveup_ev[k] = tick_q && !kill_me && st_q == ST_ON && pend_q && !lim_ok;
      assign warn_raw[k] = tick_q && st_q == ST_PD_WAIT && pg_s_q[k]
         && tmo_q == 4'(PD_TMO_TICKS - 4'h1);
      assign fault_ev[k] = f_ev;

      always_ff @(posedge i_clk or negedge rst_n) begin
         if (!rst_n) begin
            st_q <= ST_OFF;
            en_q <= 1'b0;
            pend_q <= 1'b0;
            pend_uv_q <= 1'b0;
            gave_up_q <= 1'b0;
            uv_cnt_q <= '0;
            oc_cnt_q <= '0;
            dly_q <= '0;
            tmo_q <= '0;
         end else if (f_ev) begin
            en_q <= 1'b0;
            pend_q <= 1'b1;
            pend_uv_q <= uv_hit;
         end else if (kill_me) begin
            pend_q <= 1'b0;
            // a slave not yet enabled has nothing to ramp down, so it just stops
            if (kill_imm || !en_q) begin
               en_q <= 1'b0;
               st_q <= ST_OFF;
            end else begin
               st_q <= ST_PD_DELAY;
               dly_q <= cfg_q.pd_delay;
            end
         end else if (tick_q) begin
            case (st_q)
               ST_OFF: begin
                  if (onreq_q[k] && !gave_up_q) begin
                     st_q <= ST_AWAIT_UP;
                  end else if (!onreq_q[k]) begin
                     gave_up_q <= 1'b0;
                     uv_cnt_q <= '0;
                     oc_cnt_q <= '0;
                  end
               end
               ST_AWAIT_UP: begin
                  st_q <= ST_PU_DELAY;
               end
               ST_PU_DELAY: begin
                  en_q <= 1'b1;
                  st_q <= ST_PU_WAIT;
               end
               ST_PU_WAIT: begin
                  if (!onreq_q[k]) begin
                     st_q <= ST_PD_DELAY;
                     dly_q <= cfg_q.pd_delay;
                  end else if (pg_s_q[k]) begin
                     st_q <= ST_ON;
                  end
               end
               ST_ON: begin
                  if (pend_q) begin
                     pend_q <= 1'b0;
                     if (lim_ok) begin
                        st_q <= ST_RESEQ;
                        if (lim != RETRY_UNLIM && pend_uv_q) begin
                           uv_cnt_q <= 5'(uv_cnt_q + 5'h01);
                        end else if (lim != RETRY_UNLIM) begin
                           oc_cnt_q <= 5'(oc_cnt_q + 5'h01);
                        end
                     end else begin
                        gave_up_q <= 1'b1;
                        st_q <= ST_OFF;
                     end
                  end else if (!onreq_q[k]) begin
                     st_q <= ST_PD_DELAY;
                     dly_q <= cfg_q.pd_delay;
                  end
               end
               ST_PD_DELAY: begin
                  if (dly_q == 8'h00) begin
                     en_q <= 1'b0;
                     st_q <= ST_PD_WAIT;
                     tmo_q <= '0;
                  end else begin
                     dly_q <= 8'(dly_q - 8'h01);
                  end
               end
               ST_PD_WAIT: begin
                  if (!pg_s_q[k] || tmo_q == 4'(PD_TMO_TICKS - 4'h1)) begin
                     st_q <= ST_OFF;
                  end else begin
                     tmo_q <= 4'(tmo_q + 4'h1);
                  end
               end
               ST_RESEQ: begin
                  st_q <= ST_AWAIT_UP;
               end
               default: begin
                  st_q <= ST_OFF;
               end
            endcase
         end
      end

      assign cfg_w[k] = cfg_q;
      assign st_w[k] = st_q;
      assign uvc_w[k] = uv_cnt_q;
      assign occ_w[k] = oc_cnt_q;
      assign en_w[k] = en_q;

      soft_hold_a: assert property (@(posedge i_clk) disable iff (!rst_n)
         (st_q == ST_PD_DELAY && dly_q != 8'h00) |-> en_q)
         else $error("enable dropped during soft power-down delay");
      giveup_lim_a: assert property (@(posedge i_clk) disable iff (!rst_n)
         giveup_ev[k] |=> (st_q == ST_OFF && !en_q && $past(lim) != RETRY_UNLIM))
         else $error("converter resequenced past its retry limit");
   end

   assign o_en = en_w;

   // software-owned settings
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         idx_q <= RST_INDEX;
         pin_en_q <= RST_PIN_EN;
         fmask_q <= RST_FMASK;
         wmask_q <= RST_WMASK;
         slave_q <= '0;
         onreq_q <= '0;
         irq_en_q <= '0;
      end else if (i_bus.wr) begin
         case (i_bus.addr)
            A_INDEX: idx_q <= i_bus.wdata[5:0];
            A_PIN_EN: pin_en_q <= i_bus.wdata[1:0];
            A_FMASK: fmask_q <= i_bus.wdata;
            A_WMASK: wmask_q <= i_bus.wdata;
            A_SLAVE: slave_q <= i_bus.wdata;
            A_ON_REQ: onreq_q <= i_bus.wdata;
            A_IRQ_EN: irq_en_q <= i_bus.wdata[2:0];
            default: idx_q <= idx_q;
         endcase
      end
   end

   // sticky flags: a new event in the clearing cycle survives
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         fflags_q <= '0;
         wflags_q <= '0;
      end else begin
         fflags_q <= (fflags_q & ~{32{rd_fflags}}) | fault_ev;
         wflags_q <= (wflags_q & ~{32{rd_wflags}}) | warn_ev;
      end
   end

   // pins are gated, flags are not
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_fault <= 1'b0;
         o_warn <= 1'b0;
      end else begin
         if ((|fault_ev) && pin_en_q[0]) begin
            o_fault <= 1'b1;
         end else if (rd_fflags) begin
            o_fault <= 1'b0;
         end
         if ((|warn_ev) && pin_en_q[1]) begin
            o_warn <= 1'b1;
         end else if (rd_wflags) begin
            o_warn <= 1'b0;
         end
      end
   end

   // interrupt status, write-one-to-clear, set wins
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_sts_q <= '0;
         o_irq <= 1'b0;
      end else begin
         irq_sts_q <= (irq_sts_q & ~((i_bus.wr && i_bus.addr == A_IRQ_CLR) ?
            i_bus.wdata[2:0] : 3'h0)) | {|giveup_ev, |warn_ev, |fault_ev};
         o_irq <= |(irq_sts_q & irq_en_q);
      end
   end

   // read data, valid only in the cycle after the strobe
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_rdata <= '0;
      end else if (!i_bus.rd) begin
         o_rdata <= '0;
      end else begin
         case (i_bus.addr)
            A_INDEX: o_rdata <= {26'h0, idx_q};
            A_CFG: o_rdata <= idx_ok ? {8'h0, cfg_w[idx_m1].pd_delay, 2'h0,
               cfg_w[idx_m1].oc_soft, cfg_w[idx_m1].oc_lim, 2'h0,
               cfg_w[idx_m1].uv_soft, cfg_w[idx_m1].uv_lim} : 32'h0;
            A_STATE: o_rdata <= idx_ok ? {11'h0, occ_w[idx_m1], 3'h0,
               uvc_w[idx_m1], 5'h0, st_w[idx_m1]} : 32'h0;
            A_PIN_EN: o_rdata <= {30'h0, pin_en_q};
            A_FMASK: o_rdata <= fmask_q;
            A_FFLAGS: o_rdata <= fflags_q;
            A_WMASK: o_rdata <= wmask_q;
            A_WFLAGS: o_rdata <= wflags_q;
            A_SLAVE: o_rdata <= slave_q;
            A_ON_REQ: o_rdata <= onreq_q;
            A_IRQ_STS: o_rdata <= {29'h0, irq_sts_q};
            A_IRQ_EN: o_rdata <= {29'h0, irq_en_q};
            default: o_rdata <= 32'h0;
         endcase
      end
   end

   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!rst_n);

   fault_en_drop_a: assert property ((|fault_ev) |=> ((o_en & $past(fault_ev)) == '0))
      else $error("faulted converter still enabled");
   fflag_set_a: assert property ((|fault_ev) |=> (fflags_q & $past(fault_ev))
      == $past(fault_ev)) else $error("fault flag not recorded");
   fflag_rdclr_a: assert property ((rd_fflags && fault_ev == '0) |=>
      (fflags_q == '0 && !o_fault)) else $error("fault flags or pin survived read");
   fpin_gate_a: assert property ((!pin_en_q[0] && !o_fault) |=> !o_fault)
      else $error("fault pin raised while disabled");
   wpin_gate_a: assert property ((!pin_en_q[1] && !o_warn) |=> !o_warn)
      else $error("warn pin raised while disabled");
   wflag_rdclr_a: assert property ((rd_wflags && warn_ev == '0) |=> ##0
      (wflags_q == '0 && !o_warn)) else $error("warning flags survived read");
   warn_mask_a: assert property ((warn_raw != '0 && (warn_raw & wmask_q) == '0 && wflags_q == '0
      && !rd_wflags) |=> wflags_q == '0)
      else $error("masked warning recorded");
   mask_reset_a: assert property ((!$past(rst_n) && rst_n) |-> (fmask_q == RST_FMASK
      && wmask_q == RST_WMASK && pin_en_q == RST_PIN_EN))
      else $error("masks or pin enables wrong after reset");
   read_lat_a: assert property ((i_bus.rd && i_bus.addr == A_FMASK) |=> o_rdata == $past(fmask_q))
      else $error("read data not in following cycle");
   irq_out_a: assert property ((|(irq_sts_q & irq_en_q)) |=> o_irq)
      else $error("enabled interrupt not signalled");

   fault_seen_c: cover property ((|fault_ev) ##[1:300] rd_fflags);
   giveup_c: cover property (|giveup_ev);
   warn_seen_c: cover property ((|warn_ev) && pin_en_q[1]);
   slave_kill_c: cover property (kill_soft && (slave_q & o_en) != '0);
endmodule : psfc_top

// ---- tb/psfc_conv_model.sv ----
// behavioural power converters answering their enables with power-good
`timescale 1ns/100ps
module psfc_conv_model (
   // clock
   input wire logic i_clk,
   // converter control
   input wire logic [31:0] i_en,
   input wire logic [31:0] i_stuck,
   input wire logic [31:0] i_slow,
   // converter status
   output logic [31:0] o_pgood
);
   logic [11:0] hist_q [32] = '{default: 12'h000};
   initial o_pgood = 32'h0000_0000;
   // a slow converter needs thirteen enabled cycles before its output is good
   always @(posedge i_clk) begin
      for (int k = 0; k < 32; k++) begin
         hist_q[k] <= {hist_q[k][10:0], i_en[k]};
         if (i_en[k] && (i_slow[k] ? &hist_q[k] : &hist_q[k][2:0])) begin
            o_pgood[k] <= 1'b1;
         end else if (!i_en[k] && !i_stuck[k]) begin
            o_pgood[k] <= 1'b0;
         end
      end
   end
endmodule : psfc_conv_model

// ---- tb/psfc_top_tb.sv ----
// self-checking bench of the power sequencer fault control block
`timescale 1ns/100ps
module psfc_top_tb;
   import psfc_pkg::*;
   // short tick keeps every sequencing walk to a few hundred cycles
   localparam int TK = 20;
   localparam int LIMIT = 20000;
   localparam logic [5:0] CI [5] = '{6'h20, 6'h01, 6'h10, 6'h02, 6'h05};
   localparam logic [31:0] CW [5] = '{32'h0000_3F00, 32'h00FF_003F, 32'h0000_3E01,
      32'h0000_013E, 32'hFFFF_FFFF};
   localparam logic [31:0] CE [5] = '{32'h0000_3F00, 32'h00FF_003F, 32'h0000_3E01,
      32'h0000_013E, 32'h00FF_3F3F};
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   psfc_bus_t bus = '0;
   logic [31:0] uv = '0;
   logic [31:0] oc = '0;
   logic [31:0] stuck = '0;
   logic [31:0] slow = '0;
   logic [31:0] rdata, en, pgood, rv;
   logic fault, warn, irq;
   int fail_count = 0;
   int compares = 0;
   int cyc = 0;

   always #5 clk = ~clk;

   psfc_top #(.TICK_CYCLES(TK)) i_dut (.i_clk(clk), .i_rst_b(rst_b), .i_bus(bus),
      .o_rdata(rdata), .i_pgood(pgood), .i_uv(uv), .i_oc(oc), .o_en(en), .o_fault(fault),
      .o_warn(warn), .o_irq(irq));
   psfc_conv_model i_conv (.i_clk(clk), .i_en(en), .i_stuck(stuck), .i_slow(slow),
      .o_pgood(pgood));

   task automatic finish_test;
      if (fail_count == 0 && compares > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : finish_test

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         fail_count++;
         finish_test();
      end
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      bus.wr <= 1'b0;
   endtask : wr

   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      bus.rd <= 1'b0;
      #1;
      d = rdata;
   endtask : rd

   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      rd(a, rv);
      chk(rv, e);
   endtask : rc

   task automatic cfg(input logic [5:0] n, input logic [31:0] d);
      wr(A_INDEX, {26'h0, n});
      wr(A_CFG, d);
   endtask : cfg

   task automatic wait_state(input logic [5:0] n, input logic [2:0] s, input int ticks);
      logic [31:0] v;
      wr(A_INDEX, {26'h0, n});
      for (int i = 0; i < ticks * TK / 2; i++) begin
         rd(A_STATE, v);
         if (v[2:0] === s) break;
      end
      chk({29'h0, v[2:0]}, {29'h0, s});
   endtask : wait_state

   task automatic wait_en(input int n, input logic e, input int cycles);
      for (int i = 0; i < cycles; i++) begin
         if (en[n] === e) break;
         @(posedge clk);
         #1;
      end
      chk({31'h0, en[n]}, {31'h0, e});
   endtask : wait_en

   task automatic do_reset;
      @(posedge clk);
      rst_b <= 1'b0;
      repeat (19) @(posedge clk);
      #1;
      chk(en, 32'h0);
      chk({29'h0, fault, warn, irq}, 32'h0);
      @(posedge clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge clk);
   endtask : do_reset

   initial begin
      do_reset();
      rc(A_INDEX, 32'h1);
      rc(A_PIN_EN, 32'h3);
      rc(A_FMASK, 32'hFFFF_FFFF);
      rc(A_WMASK, 32'h0);
      rc(A_STATE, 32'h0);
      rc(8'hFC, 32'h0);
      rc(A_IRQ_CLR, 32'h0);
      for (int i = 0; i < 5; i++) begin
         cfg(CI[i], CW[i]);
         rc(A_CFG, CE[i]);
      end
      cfg(6'h00, 32'h1F);
      rc(A_CFG, 32'h0);
      cfg(6'h21, 32'h1F);
      rc(A_CFG, 32'h0);
      wr(A_INDEX, 32'h20);
      rc(A_CFG, CE[0]);
      // under-voltage on a master with one retry and an immediate slave
      cfg(6'h01, 32'h0000_2001);
      cfg(6'h02, 32'h0003_1F1F);
      wr(A_SLAVE, 32'h2);
      wr(A_IRQ_EN, 32'h7);
      wr(A_ON_REQ, 32'h3);
      wait_state(6'h02, ST_ON, 10);
      wait_state(6'h01, ST_ON, 10);
      @(posedge clk);
      uv <= 32'h1;
      repeat (4) @(posedge clk);
      #1;
      chk({31'h0, en[0]}, 32'h0);
      chk({31'h0, fault}, 32'h1);
      @(posedge clk);
      uv <= '0;
      wait_en(1, 1'b0, TK + 5);
      chk({31'h0, irq}, 32'h1);
      rc(A_FFLAGS, 32'h1);
      chk({31'h0, fault}, 32'h0);
      rc(A_IRQ_STS, 32'h1);
      wr(A_IRQ_CLR, 32'h1);
      repeat (2) @(posedge clk);
      #1;
      chk({31'h0, irq}, 32'h0);
      wait_state(6'h01, ST_ON, 12);
      rc(A_STATE, 32'h0000_0104);
      @(posedge clk);
      uv <= 32'h1;
      repeat (5) @(posedge clk);
      uv <= '0;
      wait_state(6'h01, ST_OFF, 4);
      repeat (3 * TK) @(posedge clk);
      rc(A_STATE, 32'h0000_0100);
      rc(A_IRQ_STS, 32'h5);
      // over-current with the fault pin gated and a soft, slow slave
      do_reset();
      wr(A_PIN_EN, 32'h2);
      cfg(6'h01, 32'h0000_2000);
      cfg(6'h02, 32'h0003_0000);
      wr(A_SLAVE, 32'h2);
      slow <= 32'h2;
      wr(A_ON_REQ, 32'h3);
      wait_state(6'h02, ST_ON, 12);
      wait_state(6'h01, ST_ON, 12);
      @(posedge clk);
      oc <= 32'h1;
      repeat (4) @(posedge clk);
      #1;
      chk({31'h0, en[0]}, 32'h0);
      chk({31'h0, fault}, 32'h0);
      @(posedge clk);
      oc <= '0;
      repeat (TK + 5) @(posedge clk);
      #1;
      chk({31'h0, en[1]}, 32'h1);
      wait_en(1, 1'b0, 5 * TK);
      rc(A_FFLAGS, 32'h1);
      rc(A_STATE, 32'h0);
      // power-down timeout: the converter keeps its output good after enable drops
      wr(A_ON_REQ, 32'h0);
      repeat (2 * TK) @(posedge clk);
      wr(A_WMASK, 32'h1);
      wr(A_ON_REQ, 32'h1);
      wait_state(6'h01, ST_ON, 12);
      stuck <= 32'h1;
      wr(A_ON_REQ, 32'h0);
      for (int i = 0; i < 15 * TK && warn !== 1'b1; i++) @(posedge clk);
      #1;
      chk({31'h0, warn}, 32'h1);
      stuck <= '0;
      rc(A_WFLAGS, 32'h1);
      chk({31'h0, warn}, 32'h0);
      rc(A_WFLAGS, 32'h0);
      // masked fault, both pins gated, and a masked warning on the second converter
      wr(A_ON_REQ, 32'h3);
      wait_state(6'h02, ST_ON, 12);
      wait_state(6'h01, ST_ON, 12);
      wr(A_FMASK, 32'hFFFF_FFFE);
      wr(A_PIN_EN, 32'h0);
      uv <= 32'h1;
      repeat (6) @(posedge clk);
      #1;
      chk({31'h0, en[0]}, 32'h1);
      @(posedge clk);
      uv <= '0;
      stuck <= 32'h3;
      rc(A_FFLAGS, 32'h0);
      wr(A_ON_REQ, 32'h0);
      repeat (16 * TK) @(posedge clk);
      #1;
      chk({31'h0, warn}, 32'h0);
      rc(A_WFLAGS, 32'h1);
      stuck <= '0;
      finish_test();
   end
endmodule : psfc_top_tb
